// file: src/receiver_serial_port.sv
// Decided for this implementation: the APB interface to the registers and the address map.
`timescale 1ns/1ps
module receiver_serial_port
	import serial_port_pkg::*;
(
	// Clock and reset
	input wire logic clk_sys_i,
	input wire logic resetn_i,
	// APB slave
	input wire logic [7:0] paddr_i,
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [31:0] pwdata_i,
	output logic [31:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	// Straps and mode pins
	input wire logic output_port_select_i,
	input wire logic serial_master_select_i,
	input wire logic append_data_i,
	// Samples from the processing chain
	input wire iq_t iq_a_i,
	input wire iq_t iq_b_i,
	input wire logic sample_strobe_i,
	// Internal register space
	output logic int_wr_o,
	output logic [9:0] int_addr_o,
	output logic [39:0] int_wdata_o,
	input wire logic [39:0] int_rdata_i,
	// Serial link
	input wire logic bit_clock_i,
	output logic bit_clock_o,
	output logic bit_clock_oe_o,
	input wire logic frame_sync_i,
	output logic frame_sync_o,
	output logic frame_sync_oe_o,
	input wire logic serial_command_in_i,
	output logic serial_data_out_o,
	output logic serial_data_out_oe_o,
	output logic frame_end_o
);

	function automatic logic [5:0] wl_len(input logic [1:0] wl);
		case (wl)
			WL_24: wl_len = 6'h18;
			WL_32: wl_len = 6'h20;
			default: wl_len = 6'h10;
		endcase
	endfunction : wl_len

	function automatic logic [2:0] max_reads(input logic [1:0] wl);
		case (wl)
			WL_24: max_reads = 3'h3;
			WL_32: max_reads = 3'h4;
			default: max_reads = 3'h2;
		endcase
	endfunction : max_reads

	// Left justify a sample into the 32-bit shifter
	function automatic logic [31:0] fmt_sample(input logic [23:0] s, input logic [1:0] wl);
		if (wl == WL_16)
		begin
			fmt_sample = {s[23:8], 16'h0000};
		end
		else
		begin
			fmt_sample = {s[23:1], 9'h000};
		end
	endfunction : fmt_sample

	logic [CTRL_WIDTH-1:0] ctrl_reg;
	logic pready_reg;
	logic [31:0] prdata_reg;
	logic pslverr_reg;
	logic strap_done_reg;
	logic serial_sel_reg;
	logic [3:0] hc_cnt_reg;
	logic sclk_reg;
	logic sclk_prev_reg;
	logic clk_oe_reg;
	logic fs_out_reg;
	logic fs_seen_reg;
	iq_t hold_a_reg;
	iq_t hold_b_reg;
	logic data_rdy_reg;
	slot_state_t state_reg;
	logic [4:0] bit_cnt_reg;
	logic [2:0] word_cnt_reg;
	logic [31:0] shift_reg;
	logic sdo_oe_reg;
	logic fe_reg;
	logic append_reg;
	logic [15:0] frames_reg;
	logic [2:0] last_reads_reg;
	logic [15:0] cmd_sh_reg;
	logic rd_req_reg;
	logic [2:0] rd_cnt_reg;
	logic [31:0] rb_reg;
	logic [7:0] ext_reg [0:7];
	logic int_wr_reg;
	logic [9:0] int_addr_reg;
	logic [39:0] int_wdata_reg;

	logic [1:0] wl;
	logic [3:0] div;
	logic diversity;
	logic master_on;
	logic [3:0] half;
	logic tick;
	logic rise_evt;
	logic fall_evt;
	logic fs_src;
	logic [4:0] last_idx;
	logic last_bit;
	logic [2:0] n_last_word;
	logic data_last;
	logic tail_now;
	logic end_of_slot;
	logic start_ok;
	logic [31:0] next_word;
	logic [15:0] cmd_word;
	logic [7:0] rd_byte;
	logic [31:0] apb_rdata;
	logic apb_bad;

	assign wl = ctrl_reg[CTRL_WL_POS +: 2];
	assign div = ctrl_reg[CTRL_DIV_POS +: 4];
	assign diversity = ctrl_reg[CTRL_DIVERSITY_POS];
	assign master_on = serial_sel_reg & serial_master_select_i;
	// Divider zero means half the system clock, clamped to the rate limit
	assign half = (div == 4'h0) ? 4'h1 : div;
	assign tick = master_on && (hc_cnt_reg >= ((half < 4'(MIN_HALF_CYC)) ?
		4'(MIN_HALF_CYC - 1) : half - 4'h1));
	// Edge events come from the divider tick in master mode and from bit_clock_i against sclk_prev_reg otherwise
	assign rise_evt = master_on ? (tick & ~sclk_reg) : (bit_clock_i & ~sclk_prev_reg);
	assign fall_evt = master_on ? (tick & sclk_reg) : (~bit_clock_i & sclk_prev_reg);
	assign fs_src = master_on ? fs_out_reg : frame_sync_i;
	assign last_idx = 5'(wl_len(wl) - 6'h01);
	assign last_bit = bit_cnt_reg == last_idx;
	assign n_last_word = diversity ? 3'h3 : 3'h1;
	assign data_last = (state_reg == ST_DATA) && (word_cnt_reg == n_last_word);
	assign tail_now = append_data_i | rd_req_reg;
	assign end_of_slot = last_bit && ((state_reg == ST_APPEND) || (data_last && !append_reg));
	// A sync seen on the last bit chains straight into the next slot
	assign start_ok = serial_sel_reg && (wl != WL_BAD) && fs_seen_reg &&
		((state_reg == ST_IDLE) || end_of_slot);
	assign cmd_word = {cmd_sh_reg[14:0], serial_command_in_i};

	always_comb
	begin
		case (word_cnt_reg)
			3'h0: next_word = fmt_sample(hold_a_reg.q, wl);
			3'h1: next_word = fmt_sample(hold_b_reg.i, wl);
			default: next_word = fmt_sample(hold_b_reg.q, wl);
		endcase
	end

	always_comb
	begin
		case (cmd_word[10:8])
			EXT_LAR, EXT_AMR: rd_byte = ext_reg[cmd_word[10:8]];
			3'h5: rd_byte = 8'h00;
			default: rd_byte = int_rdata_i[8 * cmd_word[10:8] +: 8];
		endcase
	end

	always_comb
	begin
		apb_bad = 1'h0;
		case (paddr_i)
			CTRL_OFS: apb_rdata = 32'(ctrl_reg);
			STATUS_OFS: apb_rdata = (32'(frames_reg) << STAT_FRAMES_POS) |
				(32'(last_reads_reg) << STAT_READS_POS) |
				(32'(wl == WL_BAD) << STAT_WL_BAD_POS) |
				(32'(master_on) << STAT_MASTER_POS) |
				(32'(serial_sel_reg) << STAT_SERIAL_POS) |
				(32'(state_reg != ST_IDLE) << STAT_ACTIVE_POS);
			ADDR_OFS: apb_rdata = {22'h000000, int_addr_reg};
			default:
			begin
				apb_rdata = 32'h00000000;
				apb_bad = 1'h1;
			end
		endcase
	end

	// APB slave with one wait state
	always_ff @(posedge clk_sys_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			ctrl_reg <= CTRL_RESET;
			pready_reg <= 1'h0;
			prdata_reg <= 32'h00000000;
			pslverr_reg <= 1'h0;
		end
		else
		begin
			pready_reg <= psel_i & penable_i & ~pready_reg;
			prdata_reg <= (psel_i & penable_i & ~pready_reg) ? apb_rdata : 32'h00000000;
			pslverr_reg <= psel_i & penable_i & ~pready_reg & apb_bad;
			if (psel_i && penable_i && pready_reg && pwrite_i && (paddr_i == CTRL_OFS))
			begin
				ctrl_reg <= pwdata_i[CTRL_WIDTH-1:0];
			end
		end
	end

	// Port select strap caught once after reset release
	always_ff @(posedge clk_sys_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			strap_done_reg <= 1'h0;
			serial_sel_reg <= 1'h0;
		end
		else if (!strap_done_reg)
		begin
			strap_done_reg <= 1'h1;
			serial_sel_reg <= ~output_port_select_i;
		end
	end

	// Bit clock generation and frame sync pulse
	always_ff @(posedge clk_sys_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			hc_cnt_reg <= 4'h0;
			sclk_reg <= 1'h0;
			sclk_prev_reg <= 1'h0;
			clk_oe_reg <= 1'h0;
			fs_out_reg <= 1'h0;
		end
		else
		begin
			sclk_prev_reg <= bit_clock_i;
			clk_oe_reg <= master_on;
			if (!master_on)
			begin
				hc_cnt_reg <= 4'h0;
				sclk_reg <= 1'h0;
				fs_out_reg <= 1'h0;
			end
			else if (tick)
			begin
				hc_cnt_reg <= 4'h0;
				sclk_reg <= ~sclk_reg;
			end
			else
			begin
				hc_cnt_reg <= hc_cnt_reg + 4'h1;
			end
			if (master_on && rise_evt)
			begin
				fs_out_reg <= !fs_out_reg && !fs_seen_reg && data_rdy_reg &&
					(state_reg == ST_IDLE) && (wl != WL_BAD);
			end
		end
	end

	always_ff @(posedge clk_sys_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			fs_seen_reg <= 1'h0;
		end
		else if (fall_evt)
		begin
			fs_seen_reg <= fs_src;
		end
	end

	// Sample holding; a new strobe beats the clear at frame start
	always_ff @(posedge clk_sys_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			hold_a_reg <= '0;
			hold_b_reg <= '0;
			data_rdy_reg <= 1'h0;
		end
		else if (sample_strobe_i)
		begin
			hold_a_reg <= iq_a_i;
			hold_b_reg <= iq_b_i;
			data_rdy_reg <= 1'h1;
		end
		else if (rise_evt && start_ok)
		begin
			data_rdy_reg <= 1'h0;
		end
	end

	// Output slot sequencer, all changes on rising bit clock
	always_ff @(posedge clk_sys_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			state_reg <= ST_IDLE;
			bit_cnt_reg <= 5'h00;
			word_cnt_reg <= 3'h0;
			shift_reg <= 32'h00000000;
			sdo_oe_reg <= 1'h0;
			fe_reg <= 1'h0;
			append_reg <= 1'h0;
			frames_reg <= 16'h0000;
			last_reads_reg <= 3'h0;
		end
		else if (rise_evt)
		begin
			if (start_ok)
			begin
				state_reg <= ST_DATA;
				bit_cnt_reg <= 5'h00;
				word_cnt_reg <= 3'h0;
				shift_reg <= fmt_sample(hold_a_reg.i, wl);
				sdo_oe_reg <= 1'h1;
				fe_reg <= 1'h0;
				append_reg <= 1'h0;
				frames_reg <= frames_reg + 16'h0001;
				last_reads_reg <= rd_cnt_reg;
			end
			else if (state_reg != ST_IDLE)
			begin
				if (!last_bit)
				begin
					shift_reg <= {shift_reg[30:0], 1'h0};
					bit_cnt_reg <= bit_cnt_reg + 5'h01;
					if (bit_cnt_reg + 5'h01 == last_idx)
					begin
						fe_reg <= (state_reg == ST_APPEND) || (data_last && !tail_now);
						if (data_last)
						begin
							append_reg <= tail_now;
						end
					end
				end
				else if ((state_reg == ST_DATA) && !data_last)
				begin
					word_cnt_reg <= word_cnt_reg + 3'h1;
					bit_cnt_reg <= 5'h00;
					shift_reg <= next_word;
				end
				else if ((state_reg == ST_DATA) && append_reg)
				begin
					state_reg <= ST_APPEND;
					bit_cnt_reg <= 5'h00;
					shift_reg <= rb_reg;
				end
				else
				begin
					state_reg <= ST_IDLE;
					sdo_oe_reg <= 1'h0;
					fe_reg <= 1'h0;
					shift_reg <= 32'h00000000;
				end
			end
		end
	end

	// Command intake on falling bit clock, one command per data word
	always_ff @(posedge clk_sys_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			cmd_sh_reg <= 16'h0000;
			rd_req_reg <= 1'h0;
			rd_cnt_reg <= 3'h0;
			rb_reg <= 32'h00000000;
			int_wr_reg <= 1'h0;
			int_addr_reg <= 10'h000;
			int_wdata_reg <= 40'h0000000000;
			for (int k = 0; k < 8; k++)
			begin
				ext_reg[k] <= 8'h00;
			end
		end
		else
		begin
			int_wr_reg <= 1'h0;
			if (rise_evt && start_ok)
			begin
				rd_req_reg <= 1'h0;
				rd_cnt_reg <= 3'h0;
				rb_reg <= 32'h00000000;
			end
			else if (fall_evt && (state_reg == ST_DATA))
			begin
				cmd_sh_reg <= cmd_word;
				if ((bit_cnt_reg == 5'h00) && serial_command_in_i)
				begin
					rd_req_reg <= 1'h1;
				end
				if (bit_cnt_reg == 5'(CMD_BITS - 1))
				begin
					if (cmd_word[CMD_RD_POS] && !cmd_word[CMD_WR_POS] &&
						(rd_cnt_reg < max_reads(wl)))
					begin
						rb_reg[8 * (3 - rd_cnt_reg) +: 8] <= rd_byte;
						rd_cnt_reg <= rd_cnt_reg + 3'h1;
					end
					if (cmd_word[CMD_WR_POS] && !cmd_word[CMD_RD_POS] &&
						(cmd_word[10:8] != 3'h5))
					begin
						ext_reg[cmd_word[10:8]] <= cmd_word[7:0];
						if (cmd_word[10:8] == EXT_DR0)
						begin
							int_wr_reg <= 1'h1;
							int_addr_reg <= {ext_reg[EXT_AMR][1:0], ext_reg[EXT_LAR]};
							int_wdata_reg <= {ext_reg[EXT_DR4], ext_reg[3], ext_reg[2],
								ext_reg[1], cmd_word[7:0]};
						end
					end
				end
			end
		end
	end

	assign prdata_o = prdata_reg;
	assign pready_o = pready_reg;
	assign pslverr_o = pslverr_reg;
	assign int_wr_o = int_wr_reg;
	assign int_addr_o = int_addr_reg;
	assign int_wdata_o = int_wdata_reg;
	assign bit_clock_o = sclk_reg;
	assign bit_clock_oe_o = clk_oe_reg;
	assign frame_sync_o = fs_out_reg;
	assign frame_sync_oe_o = clk_oe_reg;
	assign serial_data_out_o = shift_reg[31];
	assign serial_data_out_oe_o = sdo_oe_reg;
	assign frame_end_o = fe_reg;

	default clocking cb @(posedge clk_sys_i);
	endclocking
	default disable iff (!resetn_i);

	sequence s_start;
		rise_evt && start_ok;
	endsequence
	sequence s_first_bit;
		serial_data_out_oe_o && (bit_cnt_reg == 5'h00) && (word_cnt_reg == 3'h0);
	endsequence

	AST_MASTER_DRIVES: assert property (master_on |=> bit_clock_oe_o && frame_sync_oe_o)
		else $error("master mode not driving clock and sync");
	AST_SLOT_START: assert property (s_start |=> s_first_bit)
		else $error("slot did not start after sync");
	AST_SYNC_ONE_BIT: assert property ($fell(fs_out_reg) |-> state_reg == ST_DATA)
		else $error("frame sync pulse not followed by slot");
	AST_SHIFT_ON_RISE: assert property ($changed(shift_reg) |-> $past(rise_evt))
		else $error("output changed away from rising edge");
	AST_CMD_ON_FALL: assert property ($changed(cmd_sh_reg) |-> $past(fall_evt))
		else $error("command sampled away from falling edge");
	AST_HIZ_IDLE: assert property ((state_reg == ST_IDLE)[*2] |-> !serial_data_out_oe_o)
		else $error("data output driven outside slot");
	AST_END_LAST_BIT: assert property (frame_end_o |-> last_bit && end_of_slot)
		else $error("frame end not on final bit");
	AST_WORD_LEN: assert property (state_reg != ST_IDLE |-> bit_cnt_reg <= last_idx)
		else $error("bit count beyond word length");
	AST_READ_LIMIT: assert property (rd_cnt_reg <= max_reads(wl))
		else $error("too many reads in frame");
	AST_APPEND_ON_READ: assert property (rise_evt && data_last && last_bit && rd_req_reg
		&& !start_ok |=> state_reg == ST_APPEND)
		else $error("read frame without readback word");
	AST_INT_WRITE: assert property (int_wr_o |-> $past(fall_evt) &&
		int_addr_o == {ext_reg[EXT_AMR][1:0], ext_reg[EXT_LAR]})
		else $error("internal write without data byte 0 write");

endmodule : receiver_serial_port

// file: src/serial_port_pkg.sv
package serial_port_pkg;
	// Register byte offsets
	localparam logic [7:0] CTRL_OFS = 8'h00;
	localparam logic [7:0] STATUS_OFS = 8'h04;
	localparam logic [7:0] ADDR_OFS = 8'h08;
	// Control fields
	localparam int CTRL_WL_POS = 0;
	localparam int CTRL_DIV_POS = 2;
	localparam int CTRL_DIVERSITY_POS = 6;
	localparam int CTRL_WIDTH = 7;
	localparam logic [6:0] CTRL_RESET = 7'h00;
	// Status fields
	localparam int STAT_ACTIVE_POS = 0;
	localparam int STAT_SERIAL_POS = 1;
	localparam int STAT_MASTER_POS = 2;
	localparam int STAT_WL_BAD_POS = 3;
	localparam int STAT_READS_POS = 8;
	localparam int STAT_FRAMES_POS = 16;
	// Word length codes
	localparam logic [1:0] WL_16 = 2'h0;
	localparam logic [1:0] WL_24 = 2'h1;
	localparam logic [1:0] WL_32 = 2'h2;
	localparam logic [1:0] WL_BAD = 2'h3;
	// Command word layout
	localparam int CMD_BITS = 16;
	localparam int CMD_RD_POS = 15;
	localparam int CMD_WR_POS = 14;
	// External interface register addresses
	localparam logic [2:0] EXT_DR0 = 3'h0;
	localparam logic [2:0] EXT_DR4 = 3'h4;
	localparam logic [2:0] EXT_LAR = 3'h6;
	localparam logic [2:0] EXT_AMR = 3'h7;
	// Bit clock limit
	localparam real SYS_CLK_MHZ = 100.0;
	localparam real BIT_CLK_MAX_MHZ = 33.5;
	localparam int MIN_HALF_CYC = int'($ceil(SYS_CLK_MHZ / (2.0 * BIT_CLK_MAX_MHZ)));
	typedef struct packed
	{
		logic [23:0] i;
		logic [23:0] q;
	} iq_t;
	typedef enum logic [1:0] {ST_IDLE, ST_DATA, ST_APPEND} slot_state_t;
endpackage : serial_port_pkg

// file: tb/dsp_port_model.sv
`timescale 1ns/1ps
module dsp_port_model
(
	// Control from the bench
	input wire logic clk_sys_i,
	input wire logic make_clock_i,
	input wire logic start_i,
	input wire logic [63:0] cmd_i,
	// Serial link
	input wire logic bit_clock_i,
	input wire logic frame_sync_i,
	input wire logic data_i,
	input wire logic data_oe_i,
	input wire logic frame_end_i,
	output logic bit_clock_o,
	output logic frame_sync_o,
	output logic command_o,
	// Capture
	output logic [159:0] rx_o,
	output logic [7:0] count_o,
	output logic fe_last_o,
	output int frames_o
);
	int starts = 0;
	int sent = 0;
	int div = 0;
	int idx = 64;
	logic busy = 1'b0;
	logic armed = 1'b0;
	initial
	begin
		bit_clock_o = 1'b0;
		frame_sync_o = 1'b0;
		command_o = 1'b0;
		rx_o = '0;
		count_o = 8'h00;
		fe_last_o = 1'b0;
		frames_o = 0;
	end
	// Half period of three system cycles; clock stands still between frames
	always @(posedge clk_sys_i)
	begin
		if (start_i)
			starts <= starts + 1;
		if (make_clock_i && (starts != sent || busy || bit_clock_o))
		begin
			div <= (div == 2) ? 0 : div + 1;
			if (div == 2)
				bit_clock_o <= ~bit_clock_o;
		end
	end
	// One sync per frame, one command bit per rising edge, low when unused
	always @(posedge bit_clock_i)
	begin
		frame_sync_o <= 1'b0;
		if (make_clock_i && starts != sent && !frame_sync_o)
		begin
			frame_sync_o <= 1'b1;
			sent <= sent + 1;
		end
		if (armed)
		begin
			command_o <= cmd_i[63];
			idx <= 1;
		end
		else if (idx < 64)
		begin
			command_o <= cmd_i[63 - idx];
			idx <= idx + 1;
		end
		else
			command_o <= 1'b0;
	end
	always @(negedge bit_clock_i)
	begin
		armed <= frame_sync_i;
		if (frame_sync_i && !busy)
		begin
			rx_o <= '0;
			count_o <= 8'h00;
			busy <= 1'b1;
		end
		else if (data_oe_i)
		begin
			rx_o <= {rx_o[158:0], data_i};
			count_o <= count_o + 8'h01;
			fe_last_o <= frame_end_i;
		end
		else if (busy && count_o != 8'h00)
		begin
			busy <= 1'b0;
			frames_o <= frames_o + 1;
		end
	end
endmodule : dsp_port_model

// file: tb/receiver_serial_port_tb.sv
`timescale 1ns/1ps
`define CHECK(a, b) begin checked++; if ((a) !== (b)) begin errors++; $display("CHECK FAILED at %0t: got %0h expected %0h", $time, (a), (b)); end end
module receiver_serial_port_tb;
	import serial_port_pkg::*;
	logic clk_sys_i = 1'b0;
	logic resetn_i = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready, pslverr, int_wr;
	logic ms = 1'b1;
	logic strap = 1'b0;
	logic append = 1'b0;
	logic strobe = 1'b0;
	logic start = 1'b0;
	logic [63:0] cmds = 64'h0;
	iq_t iq_a = {24'hA5C3E1, 24'h5A3C1E};
	iq_t iq_b = {24'h123456, 24'hFEDCBA};
	logic [9:0] int_addr;
	logic [39:0] int_wdata;
	logic bclk_d, bclk_oe, bclk_m, fs_d, fs_oe, fs_m, cmd, sdo_d, sdo_oe, fe, fe_last;
	logic [159:0] rx;
	logic [7:0] count;
	int frames;
	int errors = 0;
	int checked = 0;
	int cycles = 0;
	int writes = 0;
	logic [31:0] rd;
	logic err;
	wire logic bclk = bclk_oe ? bclk_d : bclk_m;
	wire logic fs = fs_oe ? fs_d : fs_m;
	// Data line is driven low whenever the output is not enabled
	wire logic serial_data_out = sdo_oe ? sdo_d : 1'b0;

	receiver_serial_port i_dut (.clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .paddr_i(paddr),
		.psel_i(psel), .penable_i(penable), .pwrite_i(pwrite), .pwdata_i(pwdata),
		.prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
		.output_port_select_i(strap), .serial_master_select_i(ms), .append_data_i(append),
		.iq_a_i(iq_a), .iq_b_i(iq_b), .sample_strobe_i(strobe), .int_wr_o(int_wr),
		.int_addr_o(int_addr), .int_wdata_o(int_wdata), .int_rdata_i(40'h1122_3344_0A),
		.bit_clock_i(bclk), .bit_clock_o(bclk_d), .bit_clock_oe_o(bclk_oe),
		.frame_sync_i(fs), .frame_sync_o(fs_d), .frame_sync_oe_o(fs_oe),
		.serial_command_in_i(cmd), .serial_data_out_o(sdo_d),
		.serial_data_out_oe_o(sdo_oe), .frame_end_o(fe));

	dsp_port_model i_dsp (.clk_sys_i(clk_sys_i), .make_clock_i(~ms), .start_i(start),
		.cmd_i(cmds), .bit_clock_i(bclk), .frame_sync_i(fs), .data_i(serial_data_out), .data_oe_i(sdo_oe),
		.frame_end_i(fe), .bit_clock_o(bclk_m), .frame_sync_o(fs_m), .command_o(cmd),
		.rx_o(rx), .count_o(count), .fe_last_o(fe_last), .frames_o(frames));

	always #5 clk_sys_i = ~clk_sys_i;

	always @(posedge clk_sys_i)
	begin
		cycles++;
		if (int_wr === 1'b1)
			writes++;
		if (cycles == 30000)
		begin
			errors++;
			results();
		end
	end

	task results;
		if (errors == 0 && checked > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : results

	task apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
		@(posedge clk_sys_i);
		psel <= 1'b1;
		paddr <= a;
		pwrite <= wr;
		pwdata <= wd;
		@(posedge clk_sys_i);
		penable <= 1'b1;
		@(posedge clk_sys_i);
		while (pready !== 1'b1)
			@(posedge clk_sys_i);
		// Answer taken at the rising edge that sees pready high, then released
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	// Append one left-justified word of wl bits to the expected stream
	function automatic logic [159:0] add(logic [159:0] e, logic [31:0] w, int wl);
		return (e << wl) | (w >> (32 - wl));
	endfunction : add

	function automatic logic [31:0] smp(logic [23:0] s, int wl);
		return (wl == 16) ? {s[23:8], 16'h0000} : {s[23:1], 9'h000};
	endfunction : smp

	function automatic logic [159:0] frame_exp(int wl, bit two, logic [31:0] rb, bit app);
		logic [159:0] e;
		e = add(add('0, smp(iq_a.i, wl), wl), smp(iq_a.q, wl), wl);
		if (two)
			e = add(add(e, smp(iq_b.i, wl), wl), smp(iq_b.q, wl), wl);
		return app ? add(e, rb, wl) : e;
	endfunction : frame_exp

	task run_frame(input logic [6:0] ctrl, input logic m, input logic ap, input logic [63:0] c,
		input logic [159:0] e, input logic [7:0] bits);
		int f;
		ms <= m;
		append <= ap;
		cmds <= c;
		apb(1'b1, CTRL_OFS, {25'h0, ctrl});
		f = frames;
		@(posedge clk_sys_i);
		strobe <= 1'b1;
		start <= ~m;
		@(posedge clk_sys_i);
		strobe <= 1'b0;
		start <= 1'b0;
		repeat (4000)
			if (frames == f)
				@(negedge clk_sys_i);
		`CHECK(count, bits)
		`CHECK(rx, e)
		`CHECK(fe_last, 1'b1)
		`CHECK({sdo_oe, fe}, 2'b00)
	endtask : run_frame

	initial
	begin
		repeat (20) @(posedge clk_sys_i);
		resetn_i <= 1'b1;
		apb(1'b0, CTRL_OFS, 32'h0);
		`CHECK(rd, 32'h0)
		apb(1'b0, 8'h0C, 32'h0);
		`CHECK({err, rd}, 33'h1_0000_0000)
		apb(1'b0, STATUS_OFS, 32'h0);
		`CHECK(rd[2:1], 2'b11)
		run_frame(7'h40, 1'b1, 1'b0, 64'h4703_4600_80FF_4603,
			frame_exp(16, 1, 32'h0A00_0000, 1), 8'd80);
		`CHECK(writes, 0)
		run_frame(7'h0D, 1'b1, 1'b1, {16'h4055, 48'h0}, frame_exp(24, 0, 32'h0, 1), 8'd72);
		`CHECK(writes, 1)
		`CHECK(int_addr, 10'h303)
		`CHECK(int_wdata[7:0], 8'h55)
		apb(1'b0, ADDR_OFS, 32'h0);
		`CHECK(rd[9:0], 10'h303)
		run_frame(7'h02, 1'b0, 1'b0, 64'h8600_0000_8000_0000,
			frame_exp(32, 0, 32'h030A_0000, 1), 8'd96);
		`CHECK(bclk_oe, 1'b0)
		ms <= 1'b1;
		apb(1'b1, CTRL_OFS, 32'h3);
		apb(1'b0, STATUS_OFS, 32'h0);
		`CHECK(rd[3], 1'b1)
		@(posedge clk_sys_i);
		strobe <= 1'b1;
		@(posedge clk_sys_i);
		strobe <= 1'b0;
		repeat (400) @(posedge clk_sys_i);
		`CHECK(frames, 3)
		// Second reset with the strap moved while reset is held
		resetn_i <= 1'b0;
		@(posedge clk_sys_i);
		strap <= 1'b1;
		@(posedge clk_sys_i);
		`CHECK({sdo_oe, fe, bclk_oe, int_wr}, 4'h0)
		resetn_i <= 1'b1;
		apb(1'b0, STATUS_OFS, 32'h0);
		`CHECK(rd[2:1], 2'b00)
		@(posedge clk_sys_i);
		strobe <= 1'b1;
		@(posedge clk_sys_i);
		strobe <= 1'b0;
		repeat (400) @(posedge clk_sys_i);
		`CHECK({frames, bclk_oe, sdo_oe}, {32'd3, 2'b00})
		results();
	end
endmodule : receiver_serial_port_tb
